// File: bench/tb_umc_modem_ctrl.sv
// Self-checking bench of the modem control block.
`timescale 1ns/100ps
module tb_umc_modem_ctrl;
  logic       I_CLK = 1'b0, I_RESETN = 1'b0, I_RD = 1'b0, I_WR = 1'b0, slow = 1'b0;
  logic       I_SERIAL_IN = 1'b1, I_TX_SHIFT_OUT = 1'b1, I_TX_CHAR_VALID = 1'b0;
  logic       I_RX_CHAR_READY = 1'b0, cts_n, dsr_n, ri_n, dcd_n, O_DTR_N, O_RTS_N;
  logic       O_AUX1_N, O_AUX2_N, O_SERIAL_OUT, O_RX_SHIFT_IN, O_TX_CHAR_READY;
  logic       O_RX_CHAR_VALID, O_MODEM_INT;
  logic [2:0] I_ADDR = 3'h0;
  logic [3:0] asrt = 4'h0;
  logic [7:0] I_WDATA = 8'h00, I_TX_CHAR = 8'h00, O_RDATA, O_RX_CHAR;
  int         err_count = 0, checked = 0, cyc = 0, n, m;
  always #20 I_CLK = ~I_CLK;
  umc_modem_model u_umc_modem_model (.i_clk(I_CLK), .i_resetn(I_RESETN), .i_assert(asrt),
    .i_slow(slow), .o_cts_n(cts_n), .o_dsr_n(dsr_n), .o_ri_n(ri_n), .o_dcd_n(dcd_n));
  umc_modem_ctrl u_umc_modem_ctrl (.I_CLK, .I_RESETN, .I_ADDR, .I_RD, .I_WR, .I_WDATA,
    .O_RDATA, .I_CTS_N(cts_n), .I_DSR_N(dsr_n), .I_RI_N(ri_n), .I_DCD_N(dcd_n), .O_DTR_N,
    .O_RTS_N, .O_AUX1_N, .O_AUX2_N, .I_SERIAL_IN, .O_SERIAL_OUT, .I_TX_SHIFT_OUT,
    .O_RX_SHIFT_IN, .I_TX_CHAR_VALID, .O_TX_CHAR_READY, .I_TX_CHAR, .O_RX_CHAR_VALID,
    .I_RX_CHAR_READY, .O_RX_CHAR, .O_MODEM_INT);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1 chk(O_RDATA, exp);
  endtask : rdchk
  task automatic tick(input int k);
    repeat (k) @(posedge I_CLK);
    #1;
  endtask : tick
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    rdchk(3'h4, 8'h00);
    rdchk(3'h6, 8'h00);
    for (int b = 0; b < 4; b++) begin
      wr(3'h4, 8'h01 << b);
      tick(2);
      chk({4'h0, O_AUX2_N, O_AUX1_N, O_RTS_N, O_DTR_N}, {4'h0, ~(4'h1 << b)});
    end
    wr(3'h7, 8'hA5);
    wr(3'h0, 8'h5A);
    rdchk(3'h0, 8'h00);
    rdchk(3'h7, 8'hA5);
    @(posedge I_CLK);
    I_SERIAL_IN <= 1'b0;
    tick(4);
    chk(O_RX_SHIFT_IN, 1'b0);
    wr(3'h4, 8'hFF);
    I_SERIAL_IN <= 1'b1;
    I_TX_SHIFT_OUT <= 1'b0;
    tick(4);
    chk({O_SERIAL_OUT, O_AUX2_N, O_AUX1_N, O_RTS_N, O_DTR_N, O_RX_SHIFT_IN}, 8'h3E);
    rdchk(3'h4, 8'h1F);
    rdchk(3'h6, 8'hFB);
    wr(3'h1, 8'h08);
    wr(3'h4, 8'h15);
    tick(6);
    chk(O_MODEM_INT, 1'b1);
    rdchk(3'h6, 8'h69);
    chk(O_MODEM_INT, 1'b0);
    // Receiver stalls while the sender fills the buffer until it refuses.
    n = 0;
    @(posedge I_CLK);
    I_TX_CHAR <= 8'hC0;
    I_TX_CHAR_VALID <= 1'b1;
    repeat (12) begin
      @(posedge I_CLK);
      if (O_TX_CHAR_READY === 1'b1) begin
        n++;
        I_TX_CHAR <= 8'hC0 + 8'(n);
      end
    end
    I_TX_CHAR_VALID <= 1'b0;
    I_RX_CHAR_READY <= 1'b1;
    chk(8'(n > 3 && n < 7), 8'h01);
    m = 0;
    repeat (16) begin
      @(posedge I_CLK);
      if (O_RX_CHAR_VALID === 1'b1) begin
        chk(O_RX_CHAR, 8'hC0 + 8'(m));
        m++;
      end
    end
    chk(8'(m), 8'(n));
    wr(3'h4, 8'h00);
    tick(8);
    rdchk(3'h6, 8'h06);
    for (int i = 0; i < 4; i++) begin
      @(posedge I_CLK);
      slow <= (i > 1);
      asrt[i] <= 1'b1;
      tick(8);
      chk(O_MODEM_INT, i != 2);
      rdchk(3'h6, (8'h10 << i) | (i == 2 ? 8'h00 : 8'h01 << i));
      rdchk(3'h6, 8'h10 << i);
      chk(O_MODEM_INT, 1'b0);
      @(posedge I_CLK);
      asrt[i] <= 1'b0;
      tick(8);
      rdchk(3'h6, 8'h01 << i);
    end
    @(posedge I_CLK);
    asrt[0] <= 1'b1;
    wr(3'h1, 8'h00);
    tick(8);
    chk(O_MODEM_INT, 1'b0);
    rdchk(3'h6, 8'h11);
    print_verdict();
  end
endmodule : tb_umc_modem_ctrl

// File: bench/umc_modem_model.sv
// Behavioural modem that drives the four handshake lines.
`timescale 1ns/100ps
module umc_modem_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Requested lines, one means asserted; a slow modem answers a cycle later
  input  wire logic [3:0] i_assert,
  input  wire logic       i_slow,
  // Active-low pins with pull-ups, so an idle line reads high
  output logic            o_cts_n,
  output logic            o_dsr_n,
  output logic            o_ri_n,
  output logic            o_dcd_n
);
  logic [3:0] d1_r, d2_r;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      d1_r <= 4'h0;
      d2_r <= 4'h0;
    end else begin
      d1_r <= i_assert;
      d2_r <= d1_r;
    end
  end
  assign {o_dcd_n, o_ri_n, o_dsr_n, o_cts_n} = ~(i_slow ? d2_r : d1_r);
endmodule : umc_modem_model

// File: bench/umc_modem_sva.sv
// Checker bound to the modem control block.
`timescale 1ns/100ps
module umc_modem_sva (
  // Clock, reset and register port
  input wire logic       I_CLK,
  input wire logic       I_RESETN,
  input wire logic [2:0] I_ADDR,
  input wire logic       I_WR,
  input wire logic [7:0] I_WDATA,
  input wire logic [7:0] O_RDATA,
  // Handshake, serial and interrupt pins
  input wire logic       I_CTS_N,
  input wire logic       I_DSR_N,
  input wire logic       I_RI_N,
  input wire logic       I_DCD_N,
  input wire logic       O_DTR_N,
  input wire logic       O_RTS_N,
  input wire logic       O_AUX1_N,
  input wire logic       O_AUX2_N,
  input wire logic       O_SERIAL_OUT,
  input wire logic       I_TX_SHIFT_OUT,
  input wire logic       O_RX_SHIFT_IN,
  input wire logic       O_MODEM_INT
);
  // The quiet counter lets status checks wait out the synchroniser without knowing its depth.
  logic       loop_r, ie_r;
  logic [3:0] pins_r, cnt_r, pins;
  logic [9:0] st_nxt;
  assign pins = {I_DCD_N, I_RI_N, I_DSR_N, I_CTS_N};
  always_comb begin
    st_nxt[9]   = (I_WR && I_ADDR == 3'h4) ? I_WDATA[4] : loop_r;
    st_nxt[8]   = (I_WR && I_ADDR == 3'h1) ? I_WDATA[3] : ie_r;
    st_nxt[7:4] = pins;
    st_nxt[3:0] = (pins != pins_r || loop_r) ? 4'h0 : cnt_r + {3'h0, cnt_r != 4'hF};
  end
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) {loop_r, ie_r, pins_r, cnt_r} <= 10'h0F0;
    else {loop_r, ie_r, pins_r, cnt_r} <= st_nxt;
  end
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);
  sequence wr_mc;
    I_WR && I_ADDR == 3'h4;
  endsequence
  sequence wr_then_sel;
    I_WR && I_ADDR == 3'h7 ##1 !I_WR && I_ADDR == 3'h7;
  endsequence
  sequence loop_held;
    loop_r && $past(loop_r);
  endsequence
  pins_wr_a:
    assert property (wr_mc |-> ##2 {O_AUX2_N, O_AUX1_N, O_RTS_N, O_DTR_N} ==
      ~($past(I_WDATA[3:0], 2) & {4{!$past(I_WDATA[4], 2)}})) else $error("control pins wrong");
  mark_loop_a: assert property (loop_held |-> O_SERIAL_OUT)
    else $error("serial out not marking");
  rx_loop_a: assert property (loop_held |-> O_RX_SHIFT_IN == $past(I_TX_SHIFT_OUT))
    else $error("receive input not looped");
  pins_loop_a: assert property (loop_held |-> &{O_DTR_N, O_RTS_N, O_AUX1_N, O_AUX2_N})
    else $error("control pins not high in loop");
  high_zero_a: assert property ($past(I_ADDR) == 3'h4 |-> O_RDATA[7:5] == 3'h0)
    else $error("control upper bits not zero");
  scratch_back_a: assert property (wr_then_sel |=> O_RDATA == $past(I_WDATA, 2))
    else $error("scratch readback wrong");
  status_pins_a: assert property (cnt_r > 4'h6 && $past(I_ADDR) == 3'h6 |->
    O_RDATA[7:4] == ~pins_r) else $error("status lines wrong");
  int_gate_a: assert property (!ie_r && !$past(ie_r) |-> !O_MODEM_INT)
    else $error("interrupt not gated");
endmodule : umc_modem_sva
bind umc_modem_ctrl umc_modem_sva u_umc_modem_sva (.I_CLK, .I_RESETN, .I_ADDR, .I_WR,
  .I_WDATA, .O_RDATA, .I_CTS_N, .I_DSR_N, .I_RI_N, .I_DCD_N, .O_DTR_N, .O_RTS_N, .O_AUX1_N,
  .O_AUX2_N, .O_SERIAL_OUT, .I_TX_SHIFT_OUT, .O_RX_SHIFT_IN, .O_MODEM_INT);

// File: logic/umc_fifo.sv
// Small valid/ready FIFO used on the looped-back character path.
`timescale 1ns/100ps
module umc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  // Filling side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Draining side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt;
  logic [AW-1:0]    rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic [WIDTH-1:0] dout_r, dout_nxt;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // Pointers and count
  // ----------------------------------------------------------------
  // Read data come straight from mem_r at the read pointer while the FIFO holds data; dout_r is shown only when empty.
  always_comb begin
    push     = i_in_valid && (cnt_r != AW'(0) + (AW+1)'(DEPTH));
    pop      = (cnt_r != '0) && i_out_ready;
    wp_nxt   = wp_r;
    rp_nxt   = rp_r;
    cnt_nxt  = cnt_r;
    dout_nxt = dout_r;
    if (push) begin
      wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - (AW+1)'(1);
    end
    if (cnt_nxt != '0) begin
      dout_nxt = (pop || cnt_r == '0) ? ((cnt_r > (AW+1)'(1) || !pop) ? mem_r[rp_nxt] : i_in_data)
                                      : dout_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_r   <= '0;
      rp_r   <= '0;
      cnt_r  <= '0;
      dout_r <= '0;
    end else begin
      wp_r   <= wp_nxt;
      rp_r   <= rp_nxt;
      cnt_r  <= cnt_nxt;
      dout_r <= dout_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = (cnt_r == '0) ? dout_r : ((pop || 1'b1) ? mem_r[rp_r] : dout_r);

endmodule : umc_fifo

// File: logic/umc_modem_ctrl.sv
// Modem control, modem status and scratch registers with local loopback.
`timescale 1ns/100ps
module umc_modem_ctrl (
  // Clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RESETN,
  // Register port, synchronous to I_CLK
  input  wire logic [2:0] I_ADDR,
  input  wire logic       I_RD,
  input  wire logic       I_WR,
  input  wire logic [7:0] I_WDATA,
  output logic      [7:0] O_RDATA,
  // Handshake inputs from the modem, active low pins
  input  wire logic       I_CTS_N,
  input  wire logic       I_DSR_N,
  input  wire logic       I_RI_N,
  input  wire logic       I_DCD_N,
  // Handshake outputs to the modem, active low pins
  output logic            O_DTR_N,
  output logic            O_RTS_N,
  output logic            O_AUX1_N,
  output logic            O_AUX2_N,
  // Serial pins
  input  wire logic       I_SERIAL_IN,
  output logic            O_SERIAL_OUT,
  // Hooks to the shift registers
  input  wire logic       I_TX_SHIFT_OUT,
  output logic            O_RX_SHIFT_IN,
  // Looped character path
  input  wire logic       I_TX_CHAR_VALID,
  output logic            O_TX_CHAR_READY,
  input  wire logic [7:0] I_TX_CHAR,
  output logic            O_RX_CHAR_VALID,
  input  wire logic       I_RX_CHAR_READY,
  output logic      [7:0] O_RX_CHAR,
  // Modem-status interrupt request
  output logic            O_MODEM_INT
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] hs_meta_r;
  logic [3:0] hs_sync_r;
  logic       sin_meta_r;
  logic       sin_sync_r;

  // Order is clear-to-send, set-ready, ring, carrier, matching status bits 4 to 7.
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      hs_meta_r  <= umc_pkg::LINES_RESET;
      hs_sync_r  <= umc_pkg::LINES_RESET;
      sin_meta_r <= 1'b1;
      sin_sync_r <= 1'b1;
    end else begin
      hs_meta_r  <= {I_DCD_N, I_RI_N, I_DSR_N, I_CTS_N};
      hs_sync_r  <= hs_meta_r;
      sin_meta_r <= I_SERIAL_IN;
      sin_sync_r <= sin_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Control, enable and scratch registers
  // ----------------------------------------------------------------
  logic [4:0] mc_r, mc_nxt;
  logic [3:0] ie_r, ie_nxt;
  logic [7:0] scratch_r, scratch_nxt;
  logic       loop;

  assign loop = mc_r[umc_pkg::MC_LOOP_BIT];

  always_comb begin
    mc_nxt      = mc_r;
    ie_nxt      = ie_r;
    scratch_nxt = scratch_r;
    if (I_WR) begin
      if (I_ADDR == umc_pkg::ADDR_MODEM_CTRL) begin
        mc_nxt = I_WDATA[4:0];
      end else if (I_ADDR == umc_pkg::ADDR_INT_ENABLES) begin
        ie_nxt = I_WDATA[3:0];
      end else if (I_ADDR == umc_pkg::ADDR_SCRATCH) begin
        scratch_nxt = I_WDATA;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      mc_r      <= umc_pkg::MC_RESET;
      ie_r      <= umc_pkg::IE_RESET;
      scratch_r <= umc_pkg::SCRATCH_RESET;
    end else begin
      mc_r      <= mc_nxt;
      ie_r      <= ie_nxt;
      scratch_r <= scratch_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Line state and change flags
  // ----------------------------------------------------------------
  logic [3:0] lines;
  logic [3:0] lines_r;
  logic [3:0] delta_r, delta_nxt;
  logic [3:0] events;
  logic       status_rd;

  // Lines are kept in true sense: one means asserted.
  always_comb begin
    if (loop) begin
      lines = {mc_r[umc_pkg::MC_AUX2_BIT], mc_r[umc_pkg::MC_AUX1_BIT],
               mc_r[umc_pkg::MC_DTR_BIT], mc_r[umc_pkg::MC_RTS_BIT]};
    end else begin
      lines = ~hs_sync_r;
    end
  end

  assign status_rd = I_RD && (I_ADDR == umc_pkg::ADDR_MODEM_STATUS);

  // Ring trailing edge is the pin going high, that is the true line falling.
  always_comb begin
    events[0] = lines[0] ^ lines_r[0];
    events[1] = lines[1] ^ lines_r[1];
    events[2] = lines_r[2] & ~lines[2];
    events[3] = lines[3] ^ lines_r[3];
    delta_nxt = (status_rd ? 4'h0 : delta_r) | events;
  end

  // Lines reset to deasserted, so a modem already asserting CTS, DSR or DCD at reset flags once.
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      lines_r <= 4'h0;
      delta_r <= umc_pkg::DELTA_RESET;
    end else begin
      lines_r <= lines;
      delta_r <= delta_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data, pins and interrupt
  // ----------------------------------------------------------------
  logic [7:0] rdata_nxt;
  logic       int_nxt;
  logic [3:0] pins_nxt;
  logic       serial_out_nxt;
  logic       rxin_nxt;

  always_comb begin
    rdata_nxt = 8'h00;
    if (I_ADDR == umc_pkg::ADDR_MODEM_CTRL) begin
      rdata_nxt = {3'h0, mc_r};
    end else if (I_ADDR == umc_pkg::ADDR_MODEM_STATUS) begin
      rdata_nxt = {lines, delta_r};
    end else if (I_ADDR == umc_pkg::ADDR_INT_ENABLES) begin
      rdata_nxt = {4'h0, ie_r};
    end else if (I_ADDR == umc_pkg::ADDR_SCRATCH) begin
      rdata_nxt = scratch_r;
    end
    int_nxt  = (|delta_nxt) && ie_nxt[umc_pkg::IE_MODEM_BIT];
    pins_nxt = loop ? 4'hF : ~mc_r[3:0];
    serial_out_nxt = loop ? 1'b1 : I_TX_SHIFT_OUT;
    rxin_nxt = loop ? I_TX_SHIFT_OUT : sin_sync_r;
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RDATA       <= 8'h00;
      O_MODEM_INT   <= 1'b0;
      O_DTR_N       <= 1'b1;
      O_RTS_N       <= 1'b1;
      O_AUX1_N      <= 1'b1;
      O_AUX2_N      <= 1'b1;
      O_SERIAL_OUT  <= 1'b1;
      O_RX_SHIFT_IN <= 1'b1;
    end else begin
      O_RDATA       <= rdata_nxt;
      O_MODEM_INT   <= int_nxt;
      O_DTR_N       <= pins_nxt[umc_pkg::MC_DTR_BIT];
      O_RTS_N       <= pins_nxt[umc_pkg::MC_RTS_BIT];
      O_AUX1_N      <= pins_nxt[umc_pkg::MC_AUX1_BIT];
      O_AUX2_N      <= pins_nxt[umc_pkg::MC_AUX2_BIT];
      O_SERIAL_OUT  <= serial_out_nxt;
      O_RX_SHIFT_IN <= rxin_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Looped character path
  // ----------------------------------------------------------------
  // Characters enter only in loopback; outside it the path is shut and never fills.
  logic       f_in_ready;
  logic       f_out_valid;
  logic [7:0] f_out_data;
  logic       txr_r, rxv_r;
  logic [7:0] rxc_r;
  logic       take;

  assign take = f_out_valid && (!rxv_r || I_RX_CHAR_READY);

  umc_fifo #(
    .WIDTH (umc_pkg::FIFO_WIDTH),
    .DEPTH (umc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_CLK),
    .i_resetn    (I_RESETN),
    .i_in_valid  (I_TX_CHAR_VALID && loop && txr_r),
    .o_in_ready  (f_in_ready),
    .i_in_data   (I_TX_CHAR),
    .o_out_valid (f_out_valid),
    .i_out_ready (!rxv_r || I_RX_CHAR_READY),
    .o_out_data  (f_out_data)
  );

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      txr_r <= 1'b0;
      rxv_r <= 1'b0;
      rxc_r <= 8'h00;
    end else begin
      // Ready is registered, so it drops after every accepted character.
      // Otherwise a push that fills the buffer would leave ready high for one more cycle,
      // and the character offered in that cycle would be lost.
      txr_r <= f_in_ready && loop && !(I_TX_CHAR_VALID && txr_r);
      if (take) begin
        rxv_r <= 1'b1;
        rxc_r <= f_out_data;
      end else if (I_RX_CHAR_READY) begin
        rxv_r <= 1'b0;
      end
    end
  end

  assign O_TX_CHAR_READY = txr_r;
  assign O_RX_CHAR_VALID = rxv_r;
  assign O_RX_CHAR       = rxc_r;

endmodule : umc_modem_ctrl

// File: logic/umc_pkg.sv
// Package with register selects, bit positions and reset values of the modem control block.
package umc_pkg;

  // ----------------------------------------------------------------
  // Register selects on the three-bit register select lines
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_INT_ENABLES  = 3'h1;
  localparam logic [2:0] ADDR_MODEM_CTRL   = 3'h4;
  localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH      = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MC_DTR_BIT      = 0;
  localparam int MC_RTS_BIT      = 1;
  localparam int MC_AUX1_BIT     = 2;
  localparam int MC_AUX2_BIT     = 3;
  localparam int MC_LOOP_BIT     = 4;
  localparam int IE_MODEM_BIT    = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] MC_RESET      = 5'h00;
  localparam logic [3:0] IE_RESET      = 4'h0;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [3:0] DELTA_RESET   = 4'h0;
  localparam logic [3:0] LINES_RESET   = 4'hF;

  // ----------------------------------------------------------------
  // Buffering
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_WIDTH = 8;

endpackage : umc_pkg
